// file: core/smx_regs.vh
`ifndef SMX_REGS_VH
`define SMX_REGS_VH
// register byte offsets on the apb slave
`define SMX_CFG_OFF 12'h000
`define SMX_CTL_OFF 12'h004
`define SMX_STAT_OFF 12'h008
`define SMX_GRP_OFF 12'h00C
`define SMX_GP_OFF 12'h010
`define SMX_TC_OFF 12'h014
// configuration field positions
`define SMX_RATE_LSB 0
`define SMX_RATE_MSB 2
`define SMX_SELF_BIT 3
`define SMX_TOEN_BIT 4
`define SMX_TOSEL_BIT 5
`define SMX_SOR_BIT 6
`define SMX_DOS_BIT 7
// reset value of the configuration register before capture
`define SMX_CFG_RST 8'hFF
// cycles after reset release: pin sample edge (captured two edges later) and drive edge
`define SMX_CAP_CYC 3'h1
`define SMX_DRV_CYC 3'h4
// group selects
`define SMX_SEL_CFG 4'h0
`define SMX_SEL_NET 4'hB
`define SMX_SEL_RCTL 4'hC
`define SMX_SEL_ERR 4'hD
`define SMX_SEL_TC 4'hE
`define SMX_SEL_GP 4'hF
// timeout: 200 x 2^n periods of a 10 MHz tick (100 ns = 25 cycles)
`define SMX_TICK_NS 100
`define SMX_CLK_NS 4
`define SMX_TO_BASE 200
`define SMX_TO_SHORT_EXP 2
`define SMX_TO_LONG_EXP 16
`endif

// file: core/smx_sync.v
`timescale 1ns/100ps
`include "smx_regs.vh"
// two-flop synchroniser, one per bit
module smx_sync #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rstn_i,
    input wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            // first stage is read only by the second
            always @(posedge clk_i) begin
                if (!rstn_i) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= d_i[g];
                    s2_q <= s1_q;
                end
            end
            assign q_o[g] = s2_q;
        end
    endgenerate
endmodule

// file: core/smx_watchdog.v
`timescale 1ns/100ps
`include "smx_regs.vh"
// idle timer for one output port; tick_i is the 10 MHz enable
module smx_watchdog (
    input wire clk_i,
    input wire rstn_i,
    input wire en_i,
    input wire long_i,
    input wire tick_i,
    input wire activity_i,
    output wire expired_o
);
    // products are worked out as integers, then cut to the counter width
    localparam integer SHORT_N = `SMX_TO_BASE * (1 << `SMX_TO_SHORT_EXP);
    localparam integer LONG_N = `SMX_TO_BASE * (1 << `SMX_TO_LONG_EXP);
    localparam [23:0] SHORT_LIM = SHORT_N[23:0];
    localparam [23:0] LONG_LIM = LONG_N[23:0];
    reg [23:0] cnt_q;
    reg exp_q;
    wire [23:0] lim = long_i ? LONG_LIM : SHORT_LIM;
    // count ticks of silence; a disabled timer never fires
    always @(posedge clk_i) begin
        if (!rstn_i || !en_i || activity_i) begin
            cnt_q <= 24'h000000;
            exp_q <= 1'b0;
        end else if (tick_i && !exp_q) begin
            if (cnt_q >= lim - 24'h000001) begin
                exp_q <= 1'b1;
            end
            cnt_q <= cnt_q + 24'h000001;
        end
    end
    assign expired_o = exp_q;
endmodule

// file: core/smx_top.v
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "smx_regs.vh"
// Functional notes
// - a 4-bit select picks which status group shows on the pins
// - right after reset the eight shared pins are inputs
// - after capture the shared pins are driven as status outputs
// - pins are driven from the fourth cycle after reset release
// - config pins loaded once just after reset, ignored otherwise
// - bits 2:0 set start-up transmit rate, 111 full down to 000 1/8
// - captured rate applies to all link ports together
// - bit 4 low enables output port timeouts at start-up
// - bit 5 picks 200x2^2 or 200x2^16 ticks of 10 MHz
// - bit 6 low makes output ports start on request
// - bit 7 low disables ports silent beyond the timeout
// - with timeouts off, ports may wait forever
// - rstn_i and stat_pin_oen_o are active low, others active high
// - with select stable, outputs update after each clock edge
// - select 0 config, 1-8 links, 9-10 ext, 11..15 other groups
module smx_top (
    input wire clk_i,
    input wire rstn_i,
    input wire [3:0] stat_sel_i,
    input wire [7:0] stat_pin_i,
    output reg [7:0] stat_pin_o,
    output wire [7:0] stat_pin_oen_o,
    input wire [7:0] cfg_port_stat_i,
    input wire [63:0] link_stat_i,
    input wire [15:0] ext_stat_i,
    input wire [7:0] net_disc_i,
    input wire [7:0] time_code_i,
    input wire [7:0] link_activity_i,
    output wire [2:0] tx_rate_o,
    output wire [7:0] port_tx_rate_o,
    output wire self_addr_en_o,
    output wire timeout_en_o,
    output wire timeout_long_o,
    output wire start_on_req_o,
    output wire idle_disconnect_en_o,
    output wire [7:0] port_disabled_o,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output wire pready_o,
    output reg [31:0] prdata_o,
    output wire pslverr_o
);
    localparam [1:0] ST_WAIT = 2'h0;
    localparam [1:0] ST_HOLD = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;
    // integer division kept apart so the cut to eight bits is deliberate
    localparam integer TICK_DIV_N = `SMX_TICK_NS / `SMX_CLK_NS;
    localparam [7:0] TICK_DIV = TICK_DIV_N[7:0];

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser: pins come from the board, not our clock domain
    wire [7:0] pin_sync;
    smx_sync #(
        .W(8)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(stat_pin_i),
        .q_o(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // start-up sequencer: counts edges after reset release
    reg [1:0] state_q;
    reg [2:0] cyc_q;
    reg [7:0] cfg_q;
    reg oe_q;
    // the sync delay means the capture edge sees pins from release, which
    // is why the board must hold them for the first three cycles
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            state_q <= ST_WAIT;
            cyc_q <= 3'h0;
            oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_WAIT: begin
                    cyc_q <= cyc_q + 3'h1;
                    if (cyc_q + 3'h1 == `SMX_CAP_CYC + 3'h2) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    cyc_q <= cyc_q + 3'h1;
                    // hold is entered with three edges counted, so the
                    // fourth edge after release turns the pins around
                    if (cyc_q + 3'h1 == `SMX_DRV_CYC) begin
                        state_q <= ST_RUN;
                        oe_q <= 1'b1;
                    end
                end
                ST_RUN: begin
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= ST_WAIT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration register: captured once, then software owned
    wire cap_now = (state_q == ST_WAIT) &&
        (cyc_q + 3'h1 == `SMX_CAP_CYC + 3'h2);
    wire apb_wr = psel_i && penable_i && pwrite_i;
    wire cfg_wr = apb_wr && (paddr_i == `SMX_CFG_OFF) && pstrb_i[0];
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            cfg_q <= `SMX_CFG_RST;
        end else if (cap_now) begin
            cfg_q <= pin_sync;
        end else if (cfg_wr) begin
            cfg_q <= pwdata_i[7:0];
        end
    end

    // decoded settings; pins 7:3 are active low, rate bits 2:0 are not inverted
    assign tx_rate_o = cfg_q[`SMX_RATE_MSB:`SMX_RATE_LSB];
    assign self_addr_en_o = !cfg_q[`SMX_SELF_BIT];
    assign timeout_en_o = !cfg_q[`SMX_TOEN_BIT];
    assign timeout_long_o = !cfg_q[`SMX_TOSEL_BIT];
    assign start_on_req_o = !cfg_q[`SMX_SOR_BIT];
    assign idle_disconnect_en_o = !cfg_q[`SMX_DOS_BIT];
    // one flag, rate code not 111, fans out to every link port
    assign port_tx_rate_o = {8{tx_rate_o != 3'h7}};

    ////////////////////////////////////////////////////////////////////////
    // 10 MHz tick enable for the port watchdogs
    reg [7:0] div_q;
    reg tick_q;
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            div_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (div_q == TICK_DIV - 8'h01) begin
            div_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    // per-port silence watchdogs; off means ports may block forever
    wire [7:0] expired;
    wire [7:0] act_sync;
    smx_sync #(
        .W(8)
    ) u_act (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(link_activity_i),
        .q_o(act_sync)
    );
    reg [7:0] disabled_q;
    genvar p;
    generate
        for (p = 0; p < 8; p = p + 1) begin : g_port
            smx_watchdog u_wd (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .en_i(timeout_en_o),
                .long_i(timeout_long_o),
                .tick_i(tick_q),
                .activity_i(act_sync[p]),
                .expired_o(expired[p])
            );
            // silent port is dropped only when disconnect is enabled
            always @(posedge clk_i) begin
                if (!rstn_i || act_sync[p]) begin
                    disabled_q[p] <= 1'b0;
                end else if (expired[p] && idle_disconnect_en_o) begin
                    disabled_q[p] <= 1'b1;
                end
            end
        end
    endgenerate
    assign port_disabled_o = disabled_q;

    ////////////////////////////////////////////////////////////////////////
    // software registers: general purpose byte
    reg [7:0] gp_q;
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            gp_q <= 8'h00;
        end else if (apb_wr && paddr_i == `SMX_GP_OFF && pstrb_i[0]) begin
            gp_q <= pwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status group mux
    wire [3:0] sel_sync;
    smx_sync #(
        .W(4)
    ) u_sel (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(stat_sel_i),
        .q_o(sel_sync)
    );
    reg [7:0] grp;
    wire [7:0] link_err;
    wire [1:0] ext_err;
    genvar e;
    generate
        for (e = 0; e < 8; e = e + 1) begin : g_err
            assign link_err[e] = |link_stat_i[e*8+4 -: 5];
        end
        for (e = 0; e < 2; e = e + 1) begin : g_xerr
            assign ext_err[e] = ext_stat_i[e*8];
        end
    endgenerate
    always @* begin
        grp = 8'h00;
        case (sel_sync)
            `SMX_SEL_CFG: grp = cfg_port_stat_i;
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: begin
                grp = link_stat_i[(sel_sync - 4'h1) * 8 +: 8];
            end
            4'h9: grp = ext_stat_i[7:0];
            4'hA: grp = ext_stat_i[15:8];
            `SMX_SEL_NET: grp = net_disc_i;
            `SMX_SEL_RCTL: begin
                grp = {1'b0, self_addr_en_o, start_on_req_o,
                    idle_disconnect_en_o, 2'b00, timeout_long_o,
                    timeout_en_o};
            end
            `SMX_SEL_ERR: grp = {ext_err, link_err[4:0], |cfg_port_stat_i};
            `SMX_SEL_TC: grp = time_code_i;
            `SMX_SEL_GP: grp = gp_q;
            default: grp = 8'h00;
        endcase
    end
    // registered so the pins change only after a clock edge
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            stat_pin_o <= 8'h00;
        end else begin
            stat_pin_o <= grp;
        end
    end
    assign stat_pin_oen_o = {8{!oe_q}};

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, unmapped reads give zero with slverr
    wire apb_rd = psel_i && !pwrite_i;
    reg hit;
    always @* begin
        hit = 1'b1;
        prdata_o = 32'h00000000;
        case (paddr_i)
            `SMX_CFG_OFF: prdata_o = {24'h000000, cfg_q};
            `SMX_CTL_OFF: prdata_o = {24'h000000, disabled_q};
            `SMX_STAT_OFF: prdata_o = {30'h00000000, state_q};
            `SMX_GRP_OFF: prdata_o = {24'h000000, stat_pin_o};
            `SMX_GP_OFF: prdata_o = {24'h000000, gp_q};
            `SMX_TC_OFF: prdata_o = {24'h000000, time_code_i};
            default: hit = 1'b0;
        endcase
        if (!apb_rd) begin
            prdata_o = 32'h00000000;
        end
    end
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
endmodule

// file: bench/smx_chk_sva.sv
`timescale 1ns/100ps
module smx_chk (
    input wire clk_i,
    input wire rstn_i,
    input wire [3:0] stat_sel_i,
    input wire [7:0] stat_pin_i,
    input wire [7:0] stat_pin_o,
    input wire [7:0] stat_pin_oen_o,
    input wire [7:0] time_code_i,
    input wire [2:0] tx_rate_o,
    input wire [7:0] port_tx_rate_o,
    input wire self_addr_en_o,
    input wire timeout_en_o,
    input wire timeout_long_o,
    input wire start_on_req_o,
    input wire idle_disconnect_en_o,
    input wire [7:0] port_disabled_o,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire pready_o,
    input wire pslverr_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    reg [7:0] pins_q;
    wire acc = psel_i && penable_i;
    // decodes folded back to pin polarity so one compare covers all
    wire [7:0] dec = {~idle_disconnect_en_o, ~start_on_req_o,
        ~timeout_long_o, ~timeout_en_o, ~self_addr_en_o, tx_rate_o};
    // last pin level seen while the router still listens
    always @(posedge clk_i)
        if (stat_pin_oen_o == 8'hFF)
            pins_q <= stat_pin_i;
    ////////////////////////////////////////
    AST_OEN_RESET: assert property (disable iff (1'b0)
        !rstn_i |=> stat_pin_oen_o == 8'hFF)
        else $error("pins driven during reset");
    AST_DRIVE_TIME: assert property ($rose(rstn_i) |->
        (stat_pin_oen_o == 8'hFF) [*4] ##1 stat_pin_oen_o == 8'h00)
        else $error("pin turnaround at wrong cycle");
    AST_OEN_STAYS: assert property (stat_pin_oen_o == 8'h00 |=>
        stat_pin_oen_o == 8'h00) else $error("pins released");
    AST_CAPTURE: assert property (stat_pin_oen_o == 8'h00 &&
        $past(stat_pin_oen_o) == 8'hFF |-> dec == pins_q)
        else $error("captured config differs from pins");
    AST_HOLD: assert property (stat_pin_oen_o == 8'h00 &&
        !(acc && pwrite_i) |=> $stable(dec))
        else $error("config moved without a write");
    AST_RATE_ALL: assert property (
        port_tx_rate_o == {8{tx_rate_o != 3'h7}})
        else $error("port rates disagree");
    AST_TC_GROUP: assert property (stat_pin_oen_o == 8'h00 &&
        stat_sel_i == 4'hE && $past(stat_sel_i) == 4'hE &&
        $past(stat_sel_i, 2) == 4'hE |=> stat_pin_o == $past(time_code_i))
        else $error("time code group wrong");
    AST_CTL_GROUP: assert property (stat_pin_oen_o == 8'h00 &&
        stat_sel_i == 4'hC && $past(stat_sel_i) == 4'hC &&
        $past(stat_sel_i, 2) == 4'hC |=> stat_pin_o == {1'b0,
        self_addr_en_o, start_on_req_o, idle_disconnect_en_o, 2'b00,
        timeout_long_o, timeout_en_o}) else $error("control group wrong");
    AST_NO_TIMEOUT: assert property (!timeout_en_o &&
        $past(timeout_en_o) == 1'b0 && port_disabled_o == 8'h00 |=>
        port_disabled_o == 8'h00) else $error("port dropped, timeouts off");
    AST_READY: assert property (acc |-> pready_o)
        else $error("apb wait state");
    AST_UNMAPPED: assert property (acc && paddr_i > 12'h014 |-> pslverr_o)
        else $error("unmapped access not refused");
endmodule
bind smx_top smx_chk u_chk (.*);

// file: bench/smx_board.sv
`timescale 1ns/100ps
module smx_board (
    input wire clk_i,
    input wire rstn_i,
    input wire [7:0] pull_i,
    input wire [7:0] pin_i,
    input wire [7:0] oen_i,
    output wire [7:0] level_o
);
    reg [7:0] pull_q;
    // pulls move only in reset or once the router drives, so the
    // levels stay put through the whole capture window
    always @(posedge clk_i)
        if (!rstn_i || oen_i == 8'h00)
            pull_q <= pull_i;
    ////////////////////////////////////////
    // router output wins where enabled (low), resistor level elsewhere
    assign level_o = (pin_i & ~oen_i) | (pull_q & oen_i);
endmodule

// file: bench/status_mux_and_reset_config_tb_top.sv
`timescale 1ns/100ps
module status_mux_and_reset_config_tb_top;
    logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, err;
    logic [3:0] stat_sel_i, pstrb_i;
    logic [7:0] cfg_port_stat_i, net_disc_i, time_code_i, link_activity_i;
    logic [7:0] pull, gp, cfg;
    logic [63:0] link_stat_i;
    logic [15:0] ext_stat_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, rd;
    wire [31:0] prdata_o;
    wire [7:0] stat_pin_i, stat_pin_o, stat_pin_oen_o, port_tx_rate_o;
    wire [7:0] port_disabled_o;
    wire [2:0] tx_rate_o;
    wire self_addr_en_o, timeout_en_o, timeout_long_o, start_on_req_o;
    wire idle_disconnect_en_o, pready_o, pslverr_o;
    wire [7:0] dec = {~idle_disconnect_en_o, ~start_on_req_o,
        ~timeout_long_o, ~timeout_en_o, ~self_addr_en_o, tx_rate_o};
    int n_fail, checked;
    smx_top dut (.*);
    smx_board board (.clk_i(clk_i), .rstn_i(rstn_i), .pull_i(pull),
        .pin_i(stat_pin_o), .oen_i(stat_pin_oen_o), .level_o(stat_pin_i));
    ////////////////////////////////////////
    // 250 MHz system clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (pready_o !== 1'b1) begin
            n_fail++;
            complete_run();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    // reset with a board pattern, then watch the pin turnaround
    task automatic do_reset(input logic [7:0] c);
        @(posedge clk_i);
        pull <= c;
        rstn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        check("oen_in", stat_pin_oen_o, 8'hFF);
        @(posedge clk_i);
        #1;
        check("oen_out", stat_pin_oen_o, 8'h00);
        check("decode", dec, c);
        check("rate_all", port_tx_rate_o, {8{c[2:0] != 3'h7}});
    endtask
    // expected pin byte for a select value
    function automatic logic [7:0] grp(input logic [3:0] s);
        case (s)
            4'h0: grp = cfg_port_stat_i;
            4'h9: grp = ext_stat_i[7:0];
            4'hA: grp = ext_stat_i[15:8];
            4'hB: grp = net_disc_i;
            4'hC: grp = {1'b0, ~cfg[3], ~cfg[6], ~cfg[7], 2'b00, ~cfg[5],
                ~cfg[4]};
            4'hD: begin
                // error summary: config port, links 1-5, both ext ports
                grp[0] = |cfg_port_stat_i;
                for (int n = 0; n < 5; n++)
                    grp[n + 1] = |link_stat_i[n * 8 +: 5];
                grp[6] = ext_stat_i[0];
                grp[7] = ext_stat_i[8];
            end
            4'hE: grp = time_code_i;
            4'hF: grp = gp;
            default: grp = link_stat_i[(s - 4'h1) * 8 +: 8];
        endcase
    endfunction
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, stat_sel_i} = '0;
        {cfg_port_stat_i, net_disc_i, time_code_i, link_stat_i} = '0;
        {ext_stat_i, paddr_i, pwdata_i} = '0;
        pstrb_i = 4'hF;
        link_activity_i = 8'hFE;
        pull = 8'hFF;
        gp = 8'h00;
        n_fail = 0;
        checked = 0;
        cfg = 8'($urandom(32'h644B));
        for (int i = 0; i < 11; i++) begin
            cfg = 8'($urandom);
            cfg[2:0] = i[2:0];
            if (i == 8)
                cfg = 8'h00; // board default: timeouts on, long period
            if (i == 9)
                cfg = 8'hFF;
            if (i == 10)
                cfg = 8'h67;
            do_reset(cfg);
        end
        for (int s = 0; s < 16; s++) begin
            @(posedge clk_i);
            cfg_port_stat_i <= 8'($urandom);
            link_stat_i <= {$urandom, $urandom};
            ext_stat_i <= 16'($urandom);
            net_disc_i <= 8'($urandom);
            time_code_i <= 8'($urandom);
            stat_sel_i <= s[3:0];
            repeat (4) @(posedge clk_i);
            #1;
            check("group", stat_pin_o, grp(s[3:0]));
        end
        check("hold", dec, cfg);
        // port 0 stays silent; short period is 20000 clocks
        repeat (19000) @(posedge clk_i);
        check("wd_early", port_disabled_o, 8'h00);
        repeat (2000) @(posedge clk_i);
        check("wd_late", port_disabled_o, 8'h01);
        gp = 8'($urandom);
        apb(1'b1, 12'h010, {24'h0, gp});
        apb(1'b0, 12'h010, 32'h0);
        check("gp_rd", rd, {24'h0, gp});
        @(posedge clk_i);
        stat_sel_i <= 4'hF;
        repeat (4) @(posedge clk_i);
        #1;
        check("gp_pin", stat_pin_o, gp);
        apb(1'b0, 12'h000, 32'h0);
        check("cfg_rd", rd[7:0], 8'h67);
        cfg = 8'($urandom);
        apb(1'b1, 12'h000, {24'h0, cfg});
        @(posedge clk_i);
        #1;
        check("cfg_wr", dec, cfg);
        apb(1'b0, 12'h018, 32'h0);
        check("bad_err", err, 1);
        check("bad_rd", rd, 0);
        complete_run();
    end
endmodule
